// ---- test_capacitive_touch_sense.sv ----
// Purpose: Self-checking bench of the touch sense unit.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Counts depend on oscillator phase, so reads are checked in ranges.
`timescale 1ns/1ns
module test_capacitive_touch_sense
   import tks_pkg::*;
;
   typedef struct {string nm; logic [7:0] lo; logic [7:0] hi;} tks_exp_t;
   logic        sys_clk_i = 1'b0;
   logic        rst_b_i, wr_i, rd_i, rd_seen;
   logic [15:0] addr_i;
   logic [7:0]  wr_data_i, rd_data_o;
   logic [3:0]  half;
   wire         sense_osc_i, irq_o, busy_o, slow_clk_sel_o;
   int          err_count = 0;
   int          n_tests = 0;
   int          cyc = 0;
   tks_exp_t    exp_q[$];
   tks_exp_t    e;

   tks_osc_model u_osc (.clk_i(sys_clk_i), .half_i(half), .osc_o(sense_osc_i));
   tks_cap_sense_unit uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sense_osc_i(sense_osc_i), .irq_o(irq_o),
      .busy_o(busy_o), .slow_clk_sel_o(slow_clk_sel_o));

   always #5 sys_clk_i = ~sys_clk_i;

   // ==========================================================
   // Tasks
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic cmp_rd(input string nm, input logic [7:0] lo, hi, got);
      n_tests++;
      if ($isunknown(got) || (lo === hi ? got !== lo : (got < lo || got > hi))) begin
         err_count++;
         $display("wrong value %s expected %h..%h seen %h", nm, lo, hi, got);
      end
   endtask : cmp_rd

   task automatic cmp_pin(input string nm, input logic ex, got);
      n_tests++;
      if (got !== ex) begin
         err_count++;
         $display("wrong value %s expected %b seen %b", nm, ex, got);
      end
   endtask : cmp_pin

   task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      addr_i    <= a;
      wr_data_i <= d;
      wr_i      <= w;
      rd_i      <= ~w;
      @(posedge sys_clk_i);
      wr_i      <= 1'b0;
      rd_i      <= 1'b0;
      #1;
   endtask : bus

   task automatic rd(input logic [15:0] a, input string nm, input logic [7:0] lo, hi);
      exp_q.push_back('{nm, lo, hi});
      bus(1'b0, a, 8'h00);
   endtask : rd

   task automatic load(input logic [23:0] v);
      for (int k = 0; k < 3; k++) bus(1'b1, TKS_ADDR_TIMER + 16'(k), v[8*k +: 8]);
   endtask : load

   task automatic zero_avg;
      for (int k = 0; k < 6; k++) bus(1'b1, TKS_ADDR_SLOW_AVG + 16'(k), 8'h00);
   endtask : zero_avg

   task automatic wait_idle(input int lim);
      int k;
      k = 0;
      while (busy_o === 1'b1 && k < lim) begin
         @(posedge sys_clk_i);
         k++;
      end
      repeat (2) @(posedge sys_clk_i);
      #1;
   endtask : wait_idle

   task automatic cap_run(input logic md);
      int p, n, lo, hi;
      p  = 2 + ($urandom % 4);
      n  = md ? 100 + ($urandom % 100) : 3 + ($urandom % 8);
      lo = md ? n / (2 * p) - 1 : 2 * p * (n - 1);
      hi = md ? n / (2 * p) + 2 : 2 * p * n + 4;
      half <= p[3:0];
      bus(1'b1, TKS_ADDR_FILTER, 8'h01);
      zero_avg();
      load(n[23:0]);
      bus(1'b1, TKS_ADDR_CONFIG, {1'b1, md, 6'h07});
      cmp_pin("busy", 1'b1, busy_o);
      wait_idle(3000);
      cmp_pin("busy", 1'b0, busy_o);
      cmp_pin("irq", 1'b1, irq_o);
      rd(TKS_ADDR_CAPTURE, "capture", lo[7:0], hi[7:0]);
      rd(TKS_ADDR_CAPTURE + 16'h2, "capture high", 8'h00, 8'h00);
      rd(TKS_ADDR_SLOW_AVG, "slow avg", lo[7:0], hi[7:0]);
      rd(TKS_ADDR_FAST_AVG, "fast avg", 8'(lo / 2), 8'(hi / 2));
      rd(TKS_ADDR_CONFIG, "config", {1'b1, md, 6'h06}, {1'b1, md, 6'h06});
      rd(TKS_ADDR_TIMER, "timer load", n[7:0], n[7:0]);
      bus(1'b1, TKS_ADDR_CONFIG, 8'h84);
      repeat (2) @(posedge sys_clk_i);
      #1;
      cmp_pin("irq", 1'b0, irq_o);
      $display("capture test mode %0d done", md);
   endtask : cap_run

   // ==========================================================
   // Read checker and timeout
   always @(posedge sys_clk_i) rd_seen <= rd_i;
   always @(negedge sys_clk_i) begin
      if (rd_seen === 1'b1) begin
         e = exp_q.pop_front();
         cmp_rd(e.nm, e.lo, e.hi, rd_data_o);
      end
   end
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         wrap_up();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(78));
      {rst_b_i, wr_i, rd_i, addr_i, wr_data_i, half} = '0;
      half = 4'h2;
      repeat (4) @(posedge sys_clk_i);
      rst_b_i <= 1'b1;
      rd(TKS_ADDR_CONFIG, "config reset", TKS_CONFIG_RESET, TKS_CONFIG_RESET);
      rd(TKS_ADDR_FILTER, "filter reset", TKS_FILTER_RESET, TKS_FILTER_RESET);
      rd(16'hA13F, "unmapped", 8'h00, 8'h00);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, TKS_ADDR_CONFIG, {2'b00, 2'(i), 4'h0});
         cmp_pin("clock select", 1'(i >> 1), slow_clk_sel_o);
      end
      $display("reset and clock select test done");
      cap_run(1'b0);
      cap_run(1'b1);
      // Slow internal clock: two timer ticks span 500 to 1000 cycles
      half <= 4'h5;
      load(24'h000002);
      bus(1'b1, TKS_ADDR_CONFIG, 8'hE5);
      wait_idle(1200);
      cmp_pin("busy", 1'b0, busy_o);
      rd(TKS_ADDR_CAPTURE, "slow clock capture", 8'h30, 8'h65);
      $display("slow clock test done");
      // Long mode 0 run, cut short by a start of 0
      half <= 4'h3;
      load(24'h0000C8);
      bus(1'b1, TKS_ADDR_CONFIG, 8'h85);
      repeat (5) @(posedge sys_clk_i);
      bus(1'b1, TKS_ADDR_CONFIG, 8'h84);
      cmp_pin("busy", 1'b0, busy_o);
      repeat (3) @(posedge sys_clk_i);
      #1;
      cmp_pin("irq", 1'b0, irq_o);
      rd(TKS_ADDR_CONFIG, "config", 8'h84, 8'h84);
      bus(1'b1, TKS_ADDR_CONFIG, 8'h05);
      cmp_pin("busy", 1'b0, busy_o);
      $display("abort and disable test done");
      // Auto: high threshold never wakes, then zero threshold wakes
      half <= 4'h2;
      bus(1'b1, TKS_ADDR_FILTER, 8'h40);
      bus(1'b1, TKS_ADDR_THRESH, 8'hFF);
      bus(1'b1, TKS_ADDR_THRESH + 16'h1, 8'h7F);
      zero_avg();
      load(24'h010020);
      bus(1'b1, TKS_ADDR_CONFIG, 8'hCF);
      repeat (400) @(posedge sys_clk_i);
      #1;
      cmp_pin("busy", 1'b1, busy_o);
      cmp_pin("irq", 1'b0, irq_o);
      bus(1'b1, TKS_ADDR_THRESH, 8'h00);
      bus(1'b1, TKS_ADDR_THRESH + 16'h1, 8'h00);
      wait_idle(300);
      cmp_pin("busy", 1'b0, busy_o);
      cmp_pin("irq", 1'b1, irq_o);
      $display("auto test done");
      wrap_up();
   end
endmodule : test_capacitive_touch_sense

// ---- tks_cap_sense_unit.sv ----
// Purpose: Timer/counter capture assist for capacitive touch keys.
// Assumes: Sense oscillator input is synchronous to sys_clk_i.
// Notes:   Internal clock ticks are enables: fast every cycle, slow divided.
`timescale 1ns/1ns
module tks_cap_sense_unit
   import tks_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_b_i,
   // Register port
   input  wire logic [15:0] addr_i,
   input  wire logic [7:0]  wr_data_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [7:0]  rd_data_o,
   // Sensing oscillator
   input  wire logic        sense_osc_i,
   // Status outputs
   output logic             irq_o,
   output logic             busy_o,
   output logic             slow_clk_sel_o
);

   // ==========================================================
   // State
   tks_state_t      state_q;
   tks_cfg_t        cfg_q;
   logic [7:0]      filter_q;
   logic [15:0]     thresh_q;
   logic [23:0]     load_q;
   logic [23:0]     timer_q;
   logic [23:0]     count_q;
   logic [23:0]     capture_q;
   logic [23:0]     slow_q;
   logic [23:0]     fast_q;
   logic            sense_prev_q;
   logic [15:0]     div_q;
   logic            slow_tick_q;
   logic [7:0]      rd_data_q;
   logic            irq_q;

   logic            cfg_wr;
   logic            start_cmd;
   logic            abort_cmd;
   logic            running;
   logic            sense_edge;
   logic            int_tick;
   logic            tmr_tick;
   logic            cnt_tick;
   logic            expire;
   logic [23:0]     mask;
   logic [23:0]     slow_new;
   logic [23:0]     fast_new;
   logic            detect;
   logic [2:0]      slow_sh;
   logic [2:0]      fast_sh;

   // ==========================================================
   // Helpers
   function automatic logic [23:0] avg_f(input logic [23:0] prev,
                                         input logic [23:0] cap,
                                         input logic [2:0]  sh);
      logic [30:0] acc;
      acc = {7'h00, cap} + ({7'h00, prev} << sh) - {7'h00, prev};
      return 24'((acc >> sh));
   endfunction : avg_f

   function automatic logic [23:0] put_byte(input logic [23:0] old,
                                            input logic [1:0]  idx,
                                            input logic [7:0]  val);
      logic [23:0] r;
      r = old;
      case (idx)
         2'h0:    r[7:0]   = val;
         2'h1:    r[15:8]  = val;
         2'h2:    r[23:16] = val;
         default: r        = old;
      endcase
      return r;
   endfunction : put_byte

   function automatic logic [7:0] get_byte(input logic [23:0] v,
                                           input logic [15:0] a,
                                           input logic [15:0] base);
      logic [15:0] off;
      off = a - base;
      case (off[1:0])
         2'h0:    return v[7:0];
         2'h1:    return v[15:8];
         2'h2:    return v[23:16];
         default: return 8'h00;
      endcase
   endfunction : get_byte

   function automatic logic in_word(input logic [15:0] a, input logic [15:0] base);
      return (a >= base) && (a < base + 16'h0003);
   endfunction : in_word

   // ==========================================================
   // Command decode
   assign cfg_wr    = wr_i && (addr_i == TKS_ADDR_CONFIG);
   assign start_cmd = cfg_wr && wr_data_i[TKS_BIT_START] && wr_data_i[TKS_BIT_ENABLE]; // [R13] [R19]
   assign abort_cmd = cfg_wr && !wr_data_i[TKS_BIT_START];                             // [R16]
   assign running   = (state_q == TKS_RUN);

   // ==========================================================
   // Clock sources
   // Sense input is already synchronous, so a plain edge detect suffices.
   assign sense_edge = sense_osc_i && !sense_prev_q;
   assign int_tick   = cfg_q.clk_sel[1] ? slow_tick_q : 1'b1;        // [R12]
   assign tmr_tick   = cfg_q.mode ? int_tick : sense_edge;          // [R1] [R2]
   assign cnt_tick   = cfg_q.mode ? sense_edge : int_tick;          // [R1] [R2]
   assign mask       = cfg_q.auto_mode ? TKS_AUTO_MASK : TKS_FULL_MASK; // [R10]
   // Timer loaded with zero or one expires on the very next tick.
   assign expire     = running && tmr_tick && (timer_q <= 24'h000001);

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         sense_prev_q <= 1'b0;
      end else begin
         sense_prev_q <= sense_osc_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         div_q       <= 16'h0000;
         slow_tick_q <= 1'b0;
      end else if (div_q == TKS_SLOW_DIV - 16'h0001) begin
         div_q       <= 16'h0000;
         slow_tick_q <= 1'b1;
      end else begin
         div_q       <= div_q + 16'h0001;
         slow_tick_q <= 1'b0;
      end
   end

   // ==========================================================
   // Filters
   always_comb begin
      slow_sh = 3'h0;
      fast_sh = 3'h0;
      if ((filter_q[7:4] != 4'h0) && (filter_q[7:4] <= TKS_SLOW_MAX)) begin
         slow_sh = TKS_SLOW_BASE + filter_q[6:4];
      end
      if (filter_q[3:0] <= TKS_FAST_MAX) begin
         fast_sh = filter_q[2:0];
      end
   end

   assign slow_new = avg_f(slow_q & mask, count_q & mask, slow_sh) & mask;    // [R6]
   assign fast_new = avg_f(fast_q & mask, count_q & mask, fast_sh) & mask;    // [R6]
   assign detect   = cfg_q.auto_mode &&
                     ({1'b0, fast_new} > ({1'b0, slow_new} + {9'h000, thresh_q})); // [R11]

   // ==========================================================
   // Sequencer
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state_q <= TKS_IDLE;
      end else if (abort_cmd || (cfg_wr && !wr_data_i[TKS_BIT_ENABLE])) begin
         state_q <= TKS_IDLE;                                       // [R16] [R19]
      end else if (start_cmd) begin
         state_q <= TKS_RUN;                                        // [R4]
      end else if (!cfg_q.enable || (expire && (!cfg_q.auto_mode || detect))) begin
         state_q <= TKS_IDLE;                                       // [R14] [R15] [R19]
      end
   end

   // Timer: loaded on start, reloaded after each auto capture.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         timer_q <= 24'h000000;
      end else if (start_cmd) begin
         timer_q <= load_q & (wr_data_i[TKS_BIT_AUTO] ? TKS_AUTO_MASK : TKS_FULL_MASK); // [R4] [R10]
      end else if (expire) begin
         timer_q <= load_q & mask;                                  // [R9]
      end else if (running && tmr_tick) begin
         timer_q <= timer_q - 24'h000001;                           // [R3]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         count_q <= 24'h000000;
      end else if (start_cmd || expire) begin
         count_q <= 24'h000000;                                     // [R4] [R9]
      end else if (running && cnt_tick) begin
         count_q <= (count_q + 24'h000001) & mask;                  // [R3] [R10]
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         capture_q <= 24'h000000;
      end else if (expire) begin
         capture_q <= count_q & mask;                               // [R5] [R8]
      end
   end

   // Hardware update beats a same-cycle software preload.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         slow_q <= 24'h000000;
         fast_q <= 24'h000000;
      end else if (expire) begin
         slow_q <= slow_new;                                        // [R6]
         fast_q <= fast_new;                                        // [R6]
      end else if (wr_i) begin
         if (in_word(addr_i, TKS_ADDR_SLOW_AVG)) begin
            slow_q <= put_byte(slow_q, 2'(addr_i - TKS_ADDR_SLOW_AVG), wr_data_i);
         end
         if (in_word(addr_i, TKS_ADDR_FAST_AVG)) begin
            fast_q <= put_byte(fast_q, 2'(addr_i - TKS_ADDR_FAST_AVG), wr_data_i);
         end
      end
   end

   // ==========================================================
   // Software registers
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         cfg_q <= tks_cfg_t'(TKS_CONFIG_RESET[7:1]);
      end else begin
         if (cfg_wr) begin
            cfg_q.enable    <= wr_data_i[TKS_BIT_ENABLE];
            cfg_q.mode      <= wr_data_i[TKS_BIT_MODE];
            cfg_q.clk_sel   <= wr_data_i[TKS_BIT_CLK_HI:TKS_BIT_CLK_LO];
            cfg_q.auto_mode <= wr_data_i[TKS_BIT_AUTO];
            cfg_q.irq_en    <= wr_data_i[TKS_BIT_IRQ_EN];
         end
         // Set wins over a same-cycle clear; writing 1 leaves the flag alone.
         if ((expire && !cfg_q.auto_mode) || (expire && detect)) begin
            cfg_q.irq_flag <= 1'b1;                                 // [R5] [R11] [R17]
         end else if (cfg_wr && !wr_data_i[TKS_BIT_IRQ_FLG]) begin
            cfg_q.irq_flag <= 1'b0;                                 // [R20]
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         filter_q <= TKS_FILTER_RESET;
         thresh_q <= 16'h0000;
         load_q   <= 24'h000000;
      end else if (wr_i) begin
         if (addr_i == TKS_ADDR_FILTER) begin
            filter_q <= wr_data_i;
         end
         if (addr_i == TKS_ADDR_THRESH) begin
            thresh_q[7:0] <= wr_data_i;
         end
         if (addr_i == TKS_ADDR_THRESH + 16'h0001) begin
            thresh_q[15:8] <= wr_data_i;
         end
         if (in_word(addr_i, TKS_ADDR_TIMER)) begin
            load_q <= put_byte(load_q, 2'(addr_i - TKS_ADDR_TIMER), wr_data_i);
         end
      end
   end

   // ==========================================================
   // Read port
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         rd_data_q <= 8'h00;
      end else if (rd_i) begin
         if (addr_i == TKS_ADDR_CONFIG) begin
            rd_data_q <= {cfg_q, running};                          // [R13] [R17]
         end else if (addr_i == TKS_ADDR_FILTER) begin
            rd_data_q <= filter_q;
         end else if (addr_i == TKS_ADDR_THRESH) begin
            rd_data_q <= thresh_q[7:0];
         end else if (addr_i == TKS_ADDR_THRESH + 16'h0001) begin
            rd_data_q <= thresh_q[15:8];
         end else if (in_word(addr_i, TKS_ADDR_TIMER)) begin
            rd_data_q <= get_byte(load_q, addr_i, TKS_ADDR_TIMER);
         end else if (in_word(addr_i, TKS_ADDR_CAPTURE)) begin
            rd_data_q <= get_byte(capture_q, addr_i, TKS_ADDR_CAPTURE); // [R8]
         end else if (in_word(addr_i, TKS_ADDR_SLOW_AVG)) begin
            rd_data_q <= get_byte(slow_q, addr_i, TKS_ADDR_SLOW_AVG);   // [R8]
         end else if (in_word(addr_i, TKS_ADDR_FAST_AVG)) begin
            rd_data_q <= get_byte(fast_q, addr_i, TKS_ADDR_FAST_AVG);   // [R8]
         end else begin
            rd_data_q <= 8'h00;
         end
      end else begin
         rd_data_q <= 8'h00;
      end
   end

   // ==========================================================
   // Outputs
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= cfg_q.irq_flag && cfg_q.irq_en;                   // [R20]
      end
   end

   assign rd_data_o      = rd_data_q;
   assign irq_o          = irq_q;
   assign busy_o         = running;
   assign slow_clk_sel_o = cfg_q.clk_sel[1];                        // [R12]

endmodule : tks_cap_sense_unit

// ---- tks_cap_sense_unit_chk.sv ----
// Purpose: Port-level checks of the touch sense unit.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to the unit at the foot of this file.
`timescale 1ns/1ns
module tks_chk
   import tks_pkg::*;
(
   // Clock and reset
   input wire logic        sys_clk_i,
   input wire logic        rst_b_i,
   // Register port
   input wire logic [15:0] addr_i,
   input wire logic [7:0]  wr_data_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [7:0]  rd_data_o,
   // Sense and status
   input wire logic        sense_osc_i,
   input wire logic        irq_o,
   input wire logic        busy_o,
   input wire logic        slow_clk_sel_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic cfg_wr;
   logic go_wr;

   // ==========================================================
   // Assertions
   assign cfg_wr = wr_i && (addr_i == TKS_ADDR_CONFIG);
   assign go_wr  = cfg_wr && wr_data_i[TKS_BIT_ENABLE] && wr_data_i[TKS_BIT_START];
   AST_RD_ZERO: assert property (!rd_i |=> rd_data_o == 8'h00)
      else $error("read data not zero without read");
   AST_START: assert property (go_wr |=> busy_o)
      else $error("start did not raise busy");
   AST_ABORT: assert property (cfg_wr && !wr_data_i[TKS_BIT_START] |=> !busy_o)
      else $error("abort left busy set");
   AST_OFF: assert property (cfg_wr && !wr_data_i[TKS_BIT_ENABLE] |=> !busy_o)
      else $error("disabled unit busy");
   AST_CLKSEL: assert property (cfg_wr |=> slow_clk_sel_o == $past(wr_data_i[TKS_BIT_CLK_HI]))
      else $error("clock select output wrong");
   AST_IRQ_MASK: assert property (cfg_wr && !wr_data_i[TKS_BIT_IRQ_EN] |=> ##1 !irq_o)
      else $error("irq while disabled");
   AST_IRQ_HOLD: assert property (irq_o && !cfg_wr && !$past(cfg_wr) |=> irq_o)
      else $error("irq dropped without clear");
   AST_BUSY_CAUSE: assert property ($rose(busy_o) |-> $past(go_wr))
      else $error("busy rose without start");
endmodule : tks_chk

bind tks_cap_sense_unit tks_chk u_chk (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .sense_osc_i(sense_osc_i),
   .irq_o(irq_o), .busy_o(busy_o), .slow_clk_sel_o(slow_clk_sel_o));

// ---- tks_osc_model.sv ----
// Purpose: Relaxation oscillator of a touch key, seen at the sense input.
// Assumes: Level changes only just after a rising system clock edge.
// Notes:   Runs free; the bench sets the half period in clock cycles.
`timescale 1ns/1ns
module tks_osc_model (
   // Clock
   input  wire logic       clk_i,
   // Control
   input  wire logic [3:0] half_i,
   // Sense level
   output logic            osc_o
);
   logic [3:0] cnt_q = 4'h0;
   logic       osc_q = 1'b0;

   // ==========================================================
   // Oscillation
   // Sole driver of the sense line; no other pin driver modelled
   assign osc_o = osc_q;
   always @(posedge clk_i) begin
      if (cnt_q + 4'h1 >= half_i) begin
         cnt_q <= 4'h0;
         osc_q <= ~osc_q;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule : tks_osc_model

// ---- tks_pkg.sv ----
// Purpose: Constants, register map and types of the capacitive touch sense unit.
// Assumes: 8-bit register port with byte addresses; one 100 MHz clock.
// Notes:   Multi-byte values sit low byte first at consecutive addresses.
//
// Behaviour
// R1 - Mode 0: counter internal clock, timer sense
// R2 - Mode 1: timer internal clock, counter sense
// R3 - 24-bit timer and 24-bit counter
// R4 - Start clears counter, loads timer, runs both
// R5 - Timer expiry captures count, raises interrupt
// R6 - Each capture updates slow and fast averages
// R7 - Software preloads previous averages before start
// R8 - Captured count and averages readable by software
// R9 - Auto mode repeats captures without interrupts
// R10 - Auto mode limits values to 16 bits
// R11 - Auto wakes when fast exceeds slow+threshold
// R12 - Clock select: 0x fast, 1x slow oscillator
// R13 - Bit 0 reads busy, write starts
// R14 - Start without auto does one capture
// R15 - Start with auto runs until detection
// R16 - Writing start 0 aborts capture
// R17 - Config holds interrupt enable and flag
// R18 - System enables analog pins, tristates drivers
// R19 - Disabled unit idles and ignores start
// R20 - Flag sticks until cleared; irq flag&enable
package tks_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] TKS_ADDR_CONFIG   = 16'hA130;
   localparam logic [15:0] TKS_ADDR_FILTER   = 16'hA132;
   localparam logic [15:0] TKS_ADDR_THRESH   = 16'hA133;
   localparam logic [15:0] TKS_ADDR_TIMER    = 16'hA140;
   localparam logic [15:0] TKS_ADDR_CAPTURE  = 16'hA143;
   localparam logic [15:0] TKS_ADDR_SLOW_AVG = 16'hA146;
   localparam logic [15:0] TKS_ADDR_FAST_AVG = 16'hA149;

   localparam logic [7:0]  TKS_CONFIG_RESET  = 8'h00;
   localparam logic [7:0]  TKS_FILTER_RESET  = 8'h00;

   // ==========================================================
   // Config bit positions
   localparam int TKS_BIT_ENABLE  = 7;
   localparam int TKS_BIT_MODE    = 6;
   localparam int TKS_BIT_CLK_HI  = 5;
   localparam int TKS_BIT_CLK_LO  = 4;
   localparam int TKS_BIT_AUTO    = 3;
   localparam int TKS_BIT_IRQ_EN  = 2;
   localparam int TKS_BIT_IRQ_FLG = 1;
   localparam int TKS_BIT_START   = 0;

   // ==========================================================
   // Widths and filter coding
   localparam int          TKS_W          = 24;
   localparam logic [23:0] TKS_AUTO_MASK  = 24'h00FFFF;
   localparam logic [23:0] TKS_FULL_MASK  = 24'hFFFFFF;
   localparam logic [3:0]  TKS_SLOW_MAX   = 4'h4;
   localparam logic [3:0]  TKS_FAST_MAX   = 4'h4;
   localparam logic [2:0]  TKS_SLOW_BASE  = 3'h3;
   localparam logic [15:0] TKS_SLOW_DIV   = 16'h01F4;

   typedef enum logic {TKS_IDLE, TKS_RUN} tks_state_t;

   typedef struct packed {
      logic       enable;
      logic       mode;
      logic [1:0] clk_sel;
      logic       auto_mode;
      logic       irq_en;
      logic       irq_flag;
   } tks_cfg_t;

endpackage : tks_pkg
